// ---- logic/bis_summary.sv ----
// block interrupt summary: apb slave, sub-block latches and summary register
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module bis_summary import bis_pkg::*; (
    input wire logic ref_clk, // 25 mhz register clock
    input wire logic rst, // synchronous reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [DATA_W-1:0] pwdata, // apb write data
    output logic [DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire bis_src_type raise, // sub-block event pulses
    input wire bis_src_type src_en, // source-level enables
    output logic [7:0] summary_out, // registered summary value
    output bis_rdclr_type rd_clr // status read pulses to sub-blocks
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] summary;
        logic [7:0] enable;
        logic [7:0] config_reg;
        logic [DATA_W-1:0] rdata;
        logic err;
    } bis_state_type;

    bis_state_type state_q;
    bis_state_type state_d;

    logic [11:0] ofs;
    logic access;
    logic hit_rd;
    logic pend_nb6;
    logic pend_framer;
    logic pend_slip;
    logic [NUM_ALARM-1:0] pend_alarm;
    logic [NUM_DL-1:0] pend_dl;
    logic [7:0] sum_now;
    logic mapped;
    logic [3:0] grp;

    // each register takes one aligned word, so the index sits above the
    // byte lane bits; the channel select lies beyond paddr and is decoded
    // by the chip top
    assign ofs = paddr[IDX_LSB +: IDX_W];
    assign access = psel && penable;
    assign hit_rd = access && !pwrite;

    // ------------------------------------------------------------
    // read-to-clear strobes
    // ------------------------------------------------------------
    always_comb begin
        rd_clr = '0;
        rd_clr.nb6 = hit_rd && (ofs == OFS_NB6);
        rd_clr.framer = hit_rd && (ofs == OFS_FRAMER);
        rd_clr.slip = hit_rd && (ofs == OFS_SLIP);
        rd_clr.alarm[0] = hit_rd && (ofs == OFS_ALARM_A);
        rd_clr.alarm[1] = hit_rd && (ofs == OFS_ALARM_B);
        rd_clr.alarm[2] = hit_rd && (ofs == OFS_ALARM_C);
        rd_clr.dl[0] = hit_rd && (ofs == OFS_DL_1);
        rd_clr.dl[1] = hit_rd && (ofs == OFS_DL_2);
        rd_clr.dl[2] = hit_rd && (ofs == OFS_DL_3);
        rd_clr.dl[3] = hit_rd && (ofs == OFS_DL_4);
        rd_clr.dl[4] = hit_rd && (ofs == OFS_DL_5);
        rd_clr.dl[5] = hit_rd && (ofs == OFS_DL_6);
    end

    // ------------------------------------------------------------
    // sub-block pending latches
    // ------------------------------------------------------------
    // flags latch even while masked: a source enabled later shows its old
    // request at once, so software clears the status before enabling
    logic nb6_block_on;
    assign nb6_block_on = state_q.enable[BIT_NB6_ENABLE];

    bis_src_latch u_nb6 (
        .ref_clk(ref_clk),
        .rst(rst),
        .raise(raise.nb6),
        // block enable low masks every source of the group
        .src_en(src_en.nb6 & {SRC_W{nb6_block_on}}),
        .rd_clr(rd_clr.nb6),
        .pending(pend_nb6)
    );

    bis_src_latch u_framer (
        .ref_clk(ref_clk),
        .rst(rst),
        .raise(raise.framer),
        .src_en(src_en.framer),
        .rd_clr(rd_clr.framer),
        .pending(pend_framer)
    );

    bis_src_latch u_slip (
        .ref_clk(ref_clk),
        .rst(rst),
        .raise(raise.slip),
        .src_en(src_en.slip),
        .rd_clr(rd_clr.slip),
        .pending(pend_slip)
    );

    generate
        for (genvar g = 0; g < NUM_ALARM; g++) begin : g_alarm
            bis_src_latch u_alarm (
                .ref_clk(ref_clk),
                .rst(rst),
                .raise(raise.alarm[g]),
                .src_en(src_en.alarm[g]),
                .rd_clr(rd_clr.alarm[g]),
                .pending(pend_alarm[g])
            );
        end
        for (genvar g = 0; g < NUM_DL; g++) begin : g_dl
            bis_src_latch u_dl (
                .ref_clk(ref_clk),
                .rst(rst),
                .raise(raise.dl[g]),
                .src_en(src_en.dl[g]),
                .rd_clr(rd_clr.dl[g]),
                .pending(pend_dl[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // summary composition
    // ------------------------------------------------------------
    always_comb begin
        sum_now = SUMMARY_RESET;
        sum_now[BIT_NB6] = pend_nb6;
        sum_now[BIT_T1_ONLY] = 1'b0;
        // live level, forced low while detection is switched off
        sum_now[BIT_CLK_LOSS] = raise.clk_loss && src_en.clk_loss
            && state_q.config_reg[BIT_LOSS_DETECT];
        sum_now[BIT_ONE_SEC] = raise.one_sec
            && src_en.one_sec;
        sum_now[BIT_DL] = |pend_dl;
        sum_now[BIT_SLIP] = pend_slip;
        sum_now[BIT_ALARM] = |pend_alarm;
        sum_now[BIT_FRAMER] = pend_framer;
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // sub-block status indices decode only for their read strobes; the
    // status words live in the sub-blocks and read back as zero here
    always_comb begin
        mapped = 1'b1;
        grp = 4'h0;
        unique case (ofs)
            OFS_SUMMARY: grp = 4'h1;
            OFS_ENABLE: grp = 4'h2;
            OFS_CONFIG: grp = 4'h3;
            OFS_NB6, OFS_FRAMER, OFS_SLIP, OFS_ALARM_A, OFS_ALARM_B,
            OFS_ALARM_C, OFS_DL_1, OFS_DL_2, OFS_DL_3, OFS_DL_4,
            OFS_DL_5, OFS_DL_6: grp = 4'h4;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        // summary is a registered copy of the ors; writes never reach it
        state_d.summary = sum_now;
        if (psel && !penable) begin
            state_d.err = !mapped;
            state_d.rdata = '0;
            if (!pwrite) begin
                unique case (grp)
                    4'h1: state_d.rdata = {24'h000000, state_q.summary};
                    4'h2: state_d.rdata = {24'h000000, state_q.enable};
                    4'h3: state_d.rdata = {24'h000000, state_q.config_reg};
                    default: state_d.rdata = '0;
                endcase
            end
        end
        // only enable and config take writes; any other write is dropped
        if (access && pwrite) begin
            if (grp == 4'h2) begin
                state_d.enable = pwdata[7:0];
            end
            if (grp == 4'h3) begin
                state_d.config_reg = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q.summary <= SUMMARY_RESET;
            state_q.enable <= ENABLE_RESET;
            state_q.config_reg <= CONFIG_RESET;
            state_q.rdata <= '0;
            state_q.err <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // zero wait states: read data and error are captured at the setup
    // edge, so every access phase completes at its first edge
    assign pready = 1'b1;
    assign pslverr = access && state_q.err;
    assign prdata = state_q.rdata;
    assign summary_out = state_q.summary;
endmodule : bis_summary

// ---- logic/bis_pkg.sv ----
// package: register map, field positions and carriers of the summary block
package bis_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    // register indices (channel 0 layout); the indices count aligned words,
    // so each one maps to the byte address four times it
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W = 12;
    localparam logic [11:0] OFS_SUMMARY = 12'hb00;
    localparam logic [11:0] OFS_ENABLE = 12'hb01;
    localparam logic [11:0] OFS_ALARM_A = 12'hb02;
    localparam logic [11:0] OFS_FRAMER = 12'hb04;
    localparam logic [11:0] OFS_DL_1 = 12'hb06;
    localparam logic [11:0] OFS_SLIP = 12'hb08;
    localparam logic [11:0] OFS_NB6 = 12'hb0c;
    localparam logic [11:0] OFS_ALARM_B = 12'hb0e;
    localparam logic [11:0] OFS_DL_4 = 12'hb10;
    localparam logic [11:0] OFS_DL_2 = 12'hb16;
    localparam logic [11:0] OFS_DL_5 = 12'hb18;
    localparam logic [11:0] OFS_DL_3 = 12'hb26;
    localparam logic [11:0] OFS_DL_6 = 12'hb28;
    localparam logic [11:0] OFS_ALARM_C = 12'hb40;
    localparam logic [11:0] OFS_CONFIG = 12'h100;
    // summary register bit positions
    localparam int unsigned BIT_NB6 = 7;
    localparam int unsigned BIT_T1_ONLY = 6;
    localparam int unsigned BIT_CLK_LOSS = 5;
    localparam int unsigned BIT_ONE_SEC = 4;
    localparam int unsigned BIT_DL = 3;
    localparam int unsigned BIT_SLIP = 2;
    localparam int unsigned BIT_ALARM = 1;
    localparam int unsigned BIT_FRAMER = 0;
    // enable and config bit positions
    localparam int unsigned BIT_NB6_ENABLE = 7;
    localparam int unsigned BIT_LOSS_DETECT = 0;
    localparam int unsigned NUM_DL = 6;
    localparam int unsigned NUM_ALARM = 3;
    localparam int unsigned SRC_W = 8;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // event pulses raised by the sub-blocks, one vector per sub-block, plus single clk_loss and one_sec bits
    typedef struct packed {
        logic [SRC_W-1:0] nb6;
        logic [SRC_W-1:0] framer;
        logic [SRC_W-1:0] slip;
        logic [NUM_ALARM-1:0][SRC_W-1:0] alarm;
        logic [NUM_DL-1:0][SRC_W-1:0] dl;
        logic clk_loss;
        logic one_sec;
    } bis_src_type;

    // read strobes: one pulse per sub-block status register read
    typedef struct packed {
        logic nb6;
        logic framer;
        logic slip;
        logic [NUM_ALARM-1:0] alarm;
        logic [NUM_DL-1:0] dl;
    } bis_rdclr_type;
endpackage : bis_pkg

// ---- logic/bis_src_latch.sv ----
// one sub-block's pending flags, held until its status register is read
`timescale 1ns/1ps
module bis_src_latch import bis_pkg::*; (
    input wire logic ref_clk, // 25 mhz register clock
    input wire logic rst, // synchronous reset, high
    input wire logic [SRC_W-1:0] raise, // per-source event pulses
    input wire logic [SRC_W-1:0] src_en, // source-level enables
    input wire logic rd_clr, // status register read pulse
    output logic pending // any enabled source pending
);
    typedef struct packed {
        logic [SRC_W-1:0] flag;
    } bis_latch_state_type;

    bis_latch_state_type state_q;
    bis_latch_state_type state_d;

    always_comb begin
        state_d = state_q;
        // a raise in the clearing cycle survives the read
        for (int i = 0; i < SRC_W; i++) begin
            if (rd_clr) begin
                state_d.flag[i] = 1'b0;
            end
            if (raise[i]) begin
                state_d.flag[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pending = |(state_q.flag & src_en);
endmodule : bis_src_latch

// ---- tb/bis_summary_chk.sv ----
// port assertions for the block interrupt summary
`timescale 1ns/1ps
module bis_summary_chk import bis_pkg::*; (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire bis_src_type raise, // event pulses
    input wire bis_src_type src_en, // source enables
    input wire logic [7:0] summary_out, // summary value
    input wire bis_rdclr_type rd_clr // read clear pulses
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a fresh event in the read cycle wins, so only quiet reads must clear
    sequence s_clr(c, e);
        c && e == 8'h00;
    endsequence
    property p_clr(c, e, b);
        s_clr(c, e) |=> ##1 !b;
    endproperty
    AST_RST: assert property (disable iff (1'b0) rst |=>
        summary_out == 8'h00) else $error("summary not zero after reset");
    AST_T1_BIT: assert property (!summary_out[BIT_T1_ONLY])
        else $error("reserved bit set");
    AST_SET: assert property (|(raise.framer & src_en.framer)
        |=> ##1 summary_out[BIT_FRAMER]) else $error("framer bit not set");
    AST_CLR_FR: assert property (p_clr(rd_clr.framer,
        raise.framer, summary_out[BIT_FRAMER])) else $error("framer stuck");
    AST_CLR_SLIP: assert property (p_clr(rd_clr.slip,
        raise.slip, summary_out[BIT_SLIP])) else $error("slip stuck");
    AST_CLR_NB6: assert property (p_clr(rd_clr.nb6,
        raise.nb6, summary_out[BIT_NB6])) else $error("nb6 stuck");
    AST_ONE_SECOND_TICK_FLAG: assert property (!$past(rst) |->
        summary_out[BIT_ONE_SEC] == $past(raise.one_sec & src_en.one_sec))
        else $error("one second bit wrong");
    AST_LOSS: assert property (summary_out[BIT_CLK_LOSS] |->
        $past(raise.clk_loss & src_en.clk_loss)) else $error("loss bit");
    AST_RDCLR: assert property (rd_clr != '0 |->
        psel && penable && !pwrite) else $error("clear without read");
endmodule : bis_summary_chk

bind bis_summary bis_summary_chk bis_summary_chk_i (.ref_clk(ref_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .raise(raise), .src_en(src_en), .summary_out(summary_out),
    .rd_clr(rd_clr));

// ---- tb/bis_host.sv ----
// apb host that services the summary block
`timescale 1ns/1ps
module bis_host import bis_pkg::*; (
    input wire logic ref_clk, // clock
    output logic psel, // apb select
    output logic penable, // apb access
    output logic pwrite, // apb direction
    output logic [ADDR_W-1:0] paddr, // apb address
    output logic [DATA_W-1:0] pwdata, // apb write data
    input wire logic [DATA_W-1:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr // apb error
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // software locates the source, then reads its status
    task automatic xfer(input logic w, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] r, output logic e);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // request stands until pready is sampled high at a rising edge
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        {psel, penable} <= 2'b00;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : bis_host

// ---- tb/bis_summary_tb.sv ----
// self-checking testbench for the block interrupt summary
`timescale 1ns/1ps
module bis_summary_tb import bis_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    bis_src_type raise = '0;
    bis_src_type src_en = '1;
    logic [7:0] summary_out, v;
    bis_rdclr_type rd_clr;
    int n_fail = 0;
    int n_tests = 0;
    always #20 ref_clk = ~ref_clk;
    bis_summary bis_summary_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .raise(raise),
        .src_en(src_en), .summary_out(summary_out), .rd_clr(rd_clr));
    bis_host bis_host_i (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ---
    // helpers
    // ---
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a);
        bis_host_i.xfer(1'b0, {2'b00, a, 2'b00}, 8'h00, v, e);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bis_host_i.xfer(1'b1, {2'b00, a, 2'b00}, d, v, e);
    endtask : wr
    task automatic ev(input bis_src_type s);
        @(posedge ref_clk);
        raise <= s;
        @(posedge ref_clk);
        raise <= '0;
    endtask : ev
    function automatic bis_src_type mk(input int i);
        mk = '0;
        case (i)
            0: mk.framer = 8'h80;
            1: mk.slip = 8'h01;
            2, 3, 4: mk.alarm[i-2] = 8'h10;
            11: mk.nb6 = 8'h04;
            default: mk.dl[i-5] = 8'h02;
        endcase
    endfunction : mk
    // ---
    // scenarios
    // ---
    task automatic t_reg;
        rd(OFS_SUMMARY);
        chk(v, 8'h00);
        rd(OFS_ENABLE);
        chk(v, 8'h00);
        wr(OFS_SUMMARY, 8'hff);
        rd(OFS_SUMMARY);
        chk(v, 8'h00);
        rd(12'hb03);
        chk(e, 1'b1);
        $display("test reg done");
    endtask : t_reg
    task automatic t_src;
        logic [11:0] ofs [12] = '{OFS_FRAMER, OFS_SLIP, OFS_ALARM_A,
            OFS_ALARM_B, OFS_ALARM_C, OFS_DL_1, OFS_DL_2, OFS_DL_3,
            OFS_DL_4, OFS_DL_5, OFS_DL_6, OFS_NB6};
        int unsigned bitn [12] = '{0, 2, 1, 1, 1, 3, 3, 3, 3, 3, 3, 7};
        ev(mk(11));
        rd(OFS_SUMMARY);
        chk(v, 8'h00);
        rd(OFS_NB6);
        wr(OFS_ENABLE, 8'h80);
        src_en.nb6 <= 8'h00;
        ev(mk(11));
        rd(OFS_SUMMARY);
        chk(v, 8'h00);
        // the masked flag is still latched; clear it before unmasking
        rd(OFS_NB6);
        src_en <= '1;
        for (int i = 0; i < 12; i++) begin
            ev(mk(i));
            rd(OFS_SUMMARY);
            chk(v, 8'h01 << bitn[i]);
            rd(ofs[i]);
            rd(OFS_SUMMARY);
            chk(v, 8'h00);
        end
        $display("test sources done");
    endtask : t_src
    task automatic t_lvl;
        @(posedge ref_clk);
        raise.one_sec <= 1'b1;
        raise.clk_loss <= 1'b1;
        rd(OFS_SUMMARY);
        chk(v, 8'h10);
        wr(OFS_CONFIG, 8'h01);
        rd(OFS_SUMMARY);
        chk(v, 8'h30);
        raise.one_sec <= 1'b0;
        raise.clk_loss <= 1'b0;
        rd(OFS_SUMMARY);
        chk(v, 8'h00);
        $display("test levels done");
    endtask : t_lvl
    task automatic test_done;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reg;
        t_src;
        t_lvl;
        test_done;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        test_done;
    end
endmodule : bis_summary_tb
